// file: logic/apc_pkg.sv
// Package of constants and types for the ATA power and pin-mode command block
`default_nettype none
package apc_pkg;
    // ==========================================================
    // Command opcodes
    localparam logic [7:0] OP_IDLE_A = 8'h97;
    localparam logic [7:0] OP_IDLE_B = 8'he3;
    localparam logic [7:0] OP_SLEEP_A = 8'h99;
    localparam logic [7:0] OP_SLEEP_B = 8'he6;
    localparam logic [7:0] OP_PINFN = 8'h8b;
    localparam logic [7:0] OP_SEEK = 8'h70;
    localparam logic [7:0] OP_DIAG = 8'h90;
    localparam logic [7:0] OP_INITP = 8'h91;
    // ==========================================================
    // Signature and feature codes of the pin function command
    localparam logic [7:0] SIG_CYL_HIGH = 8'h6e;
    localparam logic [7:0] SIG_CYL_LOW = 8'h44;
    localparam logic [7:0] SIG_SEC_NUM = 8'h72;
    localparam logic [7:0] SIG_SEC_CNT = 8'h50;
    localparam logic [7:0] FEAT_WP = 8'haa;
    localparam logic [7:0] FEAT_PD = 8'h55;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 10000000;
    localparam int TICK_US = 5000;
    localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
    localparam logic [7:0] IDLE_ZERO_TICKS = 8'h03;
    localparam int DEF_SLEEP_MS = 15;
    localparam logic [7:0] DEF_TICKS = 8'(DEF_SLEEP_MS * 1000 / TICK_US);
    // ==========================================================
    // Error and status bit positions, and posting masks
    localparam int ERR_BBK = 7;
    localparam int ERR_UNC = 6;
    localparam int ERR_IDNF = 4;
    localparam int ERR_ABRT = 2;
    localparam int ERR_AMNF = 0;
    localparam int ST_RDY = 6;
    localparam int ST_DWF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_CORR = 2;
    localparam int ST_ERR = 0;
    localparam logic [7:0] ERR_MASK_READ = 8'hd5;
    localparam logic [7:0] ERR_MASK_WRITE = 8'h95;
    localparam logic [7:0] ERR_MASK_CTRL = 8'h04;
    localparam logic [7:0] ERR_MASK_SEEK = 8'h14;
    localparam logic [7:0] ST_MASK_READ = 8'h75;
    localparam logic [7:0] ST_MASK_WRITE = 8'h71;
    localparam logic [7:0] ST_MASK_DIAG = 8'h51;

    typedef enum logic [1:0] {
        CL_CTRL = 2'b00,
        CL_READ = 2'b01,
        CL_WRITE = 2'b10,
        CL_DIAG = 2'b11
    } apc_class_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b10
    } apc_state_t;
endpackage
`default_nettype wire

// file: logic/apc_nvbit.sv
// Nonvolatile pin-function bit with a factory default
`timescale 1ns/1ns
`default_nettype none
module apc_nvbit
    import apc_pkg::*;
(
    input wire logic CORE_CLK, // Core clock
    input wire logic wr_en,    // Program strobe
    input wire logic wr_data,  // 1 = power-down function
    output logic rd_data       // Stored function, registered
);
    // ==========================================================
    // Storage cell: no reset, models a fused cell kept across resets
    logic cell_reg = 1'b0;
    logic cell_next;

    // Next value of the cell
    always_comb begin
        cell_next = wr_en ? wr_data : cell_reg;
    end

    // Cell and its registered read port
    always_ff @(posedge CORE_CLK) begin
        cell_reg <= cell_next;
    end

    assign rd_data = cell_reg;
endmodule // apc_nvbit
`default_nettype wire

// file: logic/apc_cmd.sv
// ATA idle, sleep and pin-function command interpreter
`timescale 1ns/1ns
`default_nettype none
module apc_cmd
    import apc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC // Cycles in one 5 ms tick
) (
    input wire logic CORE_CLK,        // Core clock, 10 MHz
    input wire logic NRST,            // Synchronous reset, active low
    input wire logic CMD_VALID,       // Command register written, pulse
    input wire logic [7:0] CMD_CODE,  // Command opcode
    input wire logic [7:0] FEATURE,   // Feature register
    input wire logic [7:0] SEC_CNT,   // Sector count register
    input wire logic [7:0] SEC_NUM,   // Sector number register
    input wire logic [7:0] CYL_LOW,   // Cylinder low register
    input wire logic [7:0] CYL_HIGH,  // Cylinder high register
    input wire logic [1:0] CMD_CLASS, // Class of command for error posting
    input wire logic [7:0] ERR_RAW,   // Error bits from the media engine
    input wire logic [7:0] STAT_RAW,  // Status bits from the media engine
    input wire logic HOST_RESET,      // Host reset, also wakes the drive
    output logic BUSY,                // Busy status bit
    output logic INTRQ,               // Host interrupt, one-cycle pulse
    output logic SLEEPING,            // Drive in sleep mode
    output logic AUTO_PD_EN,          // Automatic power-down enabled
    output logic PIN_IS_PD,           // Multi-purpose pin used as power-down
    output logic [7:0] ERR_OUT,       // Posted error register
    output logic [7:0] STAT_OUT       // Posted status register
);
    // ==========================================================
    // Error posting masks by command class
    function automatic logic [15:0] post_mask(input logic [1:0] cls, input logic seek);
        logic [15:0] m;
        m = {ERR_MASK_CTRL, ST_MASK_WRITE};
        if (cls == CL_READ) begin
            m = {ERR_MASK_READ, ST_MASK_READ};
        end else if (cls == CL_WRITE) begin
            m = {ERR_MASK_WRITE, ST_MASK_WRITE};
        end else if (cls == CL_DIAG) begin
            m = {8'h00, ST_MASK_DIAG};
        end else if (seek) begin
            m = {ERR_MASK_SEEK, ST_MASK_WRITE};
        end
        return m;
    endfunction

    // ==========================================================
    // State
    apc_state_t state_reg, state_next;
    logic [7:0] op_reg, op_next;
    logic [7:0] feat_reg, feat_next;
    logic [7:0] cnt_reg, cnt_next;
    logic sig_ok_reg, sig_ok_next;
    logic [1:0] cls_reg, cls_next;
    logic sleep_reg, sleep_next;
    logic auto_reg, auto_next;
    logic [7:0] ticks_reg, ticks_next;
    logic [7:0] left_reg, left_next;
    logic [31:0] div_reg, div_next;
    logic [7:0] err_reg, err_next;
    logic [7:0] stat_reg, stat_next;
    logic nv_wr, nv_data, nv_q;
    logic is_idle, is_sleep, is_pin, pin_valid, abort;
    logic [15:0] mask;

    // Nonvolatile pin function cell, not touched by reset
    apc_nvbit u_nv (
        .CORE_CLK(CORE_CLK),
        .wr_en(nv_wr),
        .wr_data(nv_data),
        .rd_data(nv_q)
    );

    // Decode of the captured command
    always_comb begin
        is_idle = (op_reg == OP_IDLE_A) || (op_reg == OP_IDLE_B);
        is_sleep = (op_reg == OP_SLEEP_A) || (op_reg == OP_SLEEP_B);
        is_pin = (op_reg == OP_PINFN);
        pin_valid = sig_ok_reg && ((feat_reg == FEAT_WP) || (feat_reg == FEAT_PD));
        abort = is_pin && !pin_valid;
        mask = post_mask(cls_reg, op_reg == OP_SEEK);
    end

    // ==========================================================
    // Command sequencer and power timer, next values
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        feat_next = feat_reg;
        cnt_next = cnt_reg;
        sig_ok_next = sig_ok_reg;
        cls_next = cls_reg;
        sleep_next = sleep_reg;
        auto_next = auto_reg;
        ticks_next = ticks_reg;
        left_next = left_reg;
        div_next = div_reg;
        err_next = err_reg;
        stat_next = stat_reg;
        nv_wr = 1'b0;
        nv_data = 1'b0;
        // Inactivity countdown runs only while awake and enabled
        if (state_reg == ST_IDLE && auto_reg && !sleep_reg) begin
            if (div_reg >= 32'(TICK_CYCLES - 1)) begin
                div_next = 32'h0;
                if (left_reg <= 8'h01) begin
                    sleep_next = 1'b1;
                    left_next = 8'h00;
                end else begin
                    left_next = left_reg - 8'h01;
                end
            end else begin
                div_next = div_reg + 32'h1;
            end
        end
        if (HOST_RESET) begin
            sleep_next = 1'b0;
        end
        case (state_reg)
            ST_IDLE: begin
                if (CMD_VALID) begin
                    state_next = ST_BUSY;
                    sleep_next = 1'b0;
                    op_next = CMD_CODE;
                    feat_next = FEATURE;
                    cnt_next = SEC_CNT;
                    cls_next = CMD_CLASS;
                    sig_ok_next = (CYL_HIGH == SIG_CYL_HIGH) && (CYL_LOW == SIG_CYL_LOW)
                        && (SEC_NUM == SIG_SEC_NUM) && (SEC_CNT == SIG_SEC_CNT);
                end
            end
            ST_BUSY: begin
                state_next = ST_DONE;
                if (is_idle) begin
                    sleep_next = 1'b0;
                    auto_next = 1'b1;
                    ticks_next = (cnt_reg != 8'h00) ? cnt_reg : IDLE_ZERO_TICKS;
                end
                if (is_sleep) begin
                    sleep_next = 1'b1;
                end
                if (is_pin && pin_valid) begin
                    nv_wr = 1'b1;
                    nv_data = (feat_reg == FEAT_PD);
                end
                if (abort) begin
                    err_next = 8'h00;
                    err_next[ERR_ABRT] = 1'b1;
                    stat_next = 8'h00;
                    stat_next[ST_RDY] = 1'b1;
                    stat_next[ST_DSC] = 1'b1;
                    stat_next[ST_ERR] = 1'b1;
                end else begin
                    err_next = ERR_RAW & mask[15:8];
                    stat_next = STAT_RAW & mask[7:0];
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
                left_next = ticks_reg;
                div_next = 32'h0;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Register update
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            state_reg <= ST_IDLE;
            op_reg <= 8'h00;
            feat_reg <= 8'h00;
            cnt_reg <= 8'h00;
            sig_ok_reg <= 1'b0;
            cls_reg <= 2'b00;
            sleep_reg <= 1'b0;
            auto_reg <= 1'b1;
            ticks_reg <= DEF_TICKS;
            left_reg <= DEF_TICKS;
            div_reg <= 32'h0;
            err_reg <= 8'h00;
            stat_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            feat_reg <= feat_next;
            cnt_reg <= cnt_next;
            sig_ok_reg <= sig_ok_next;
            cls_reg <= cls_next;
            sleep_reg <= sleep_next;
            auto_reg <= auto_next;
            ticks_reg <= ticks_next;
            left_reg <= left_next;
            div_reg <= div_next;
            err_reg <= err_next;
            stat_reg <= stat_next;
        end
    end

    // ==========================================================
    // Outputs; interrupt pulses in the last busy cycle, one cycle before busy drops
    assign BUSY = (state_reg != ST_IDLE);
    assign INTRQ = (state_reg == ST_DONE);
    assign SLEEPING = sleep_reg;
    assign AUTO_PD_EN = auto_reg;
    assign PIN_IS_PD = nv_q;
    assign ERR_OUT = err_reg;
    assign STAT_OUT = stat_reg;

    // ==========================================================
    // Checks
    idle_done_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (state_reg == ST_BUSY && is_idle) |=> (INTRQ && !SLEEPING && AUTO_PD_EN))
        else $error("idle did not complete");
    idle_ticks_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (state_reg == ST_BUSY && is_idle && cnt_reg != 8'h00) |=> (ticks_reg == $past(cnt_reg)))
        else $error("idle count not loaded");
    idle_zero_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (state_reg == ST_BUSY && is_idle && cnt_reg == 8'h00) |=> (ticks_reg == 8'h03))
        else $error("zero count not three");
    sleep_cmd_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (state_reg == ST_BUSY && is_sleep) |=> (SLEEPING && INTRQ) ##1 !BUSY)
        else $error("sleep command failed");
    wake_cmd_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (state_reg == ST_IDLE && CMD_VALID) |=> (!SLEEPING && BUSY))
        else $error("command did not wake");
    pin_mode_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (state_reg == ST_BUSY && is_pin && pin_valid) |=> (PIN_IS_PD == (feat_reg == FEAT_PD)))
        else $error("pin function not set");
    pin_abort_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (state_reg == ST_BUSY && abort) |=> (ERR_OUT == 8'h04 && $stable(PIN_IS_PD)))
        else $error("bad signature not aborted");
    write_bits_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (state_reg == ST_BUSY && cls_reg == CL_WRITE && !abort)
        |=> (!ERR_OUT[ERR_UNC] && !STAT_OUT[ST_CORR]))
        else $error("write posted UNC or CORR");
    restart_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
        (state_reg == ST_DONE) |=> (left_reg == ticks_reg && div_reg == 32'h0))
        else $error("timer not restarted");
endmodule // apc_cmd
`default_nettype wire

// file: dv/apc_host.sv
// Host task-file model that issues commands to the command block
`timescale 1ns/1ns
`default_nettype none
module apc_host
    import apc_pkg::*;
(
    input wire logic clk,        // Core clock
    input wire logic busy,       // Busy from the drive
    input wire logic intrq,      // Interrupt pulse from the drive
    input wire logic [7:0] stat, // Posted status
    output logic valid,          // Command strobe
    output logic [7:0] code,     // Opcode
    output logic [7:0] feat,     // Feature
    output logic [7:0] cnt,      // Sector count
    output logic [7:0] num,      // Sector number
    output logic [7:0] cyl_lo,   // Cylinder low
    output logic [7:0] cyl_hi,   // Cylinder high
    output logic [1:0] cls       // Command class
);
    int n_busy;
    int n_int;
    // ==========================================================
    // Idle task file
    initial begin
        valid = 1'b0;
        {code, feat, cnt, num, cyl_lo, cyl_hi, cls} = '0;
    end
    // One command: strobe for one edge, then count busy and interrupt cycles
    task automatic xfer(input logic [49:0] f);
        @(posedge clk);
        valid <= 1'b1;
        {code, feat, cnt, num, cyl_lo, cyl_hi, cls} <= f;
        @(posedge clk);
        valid <= 1'b0;
        // Released lines except the class carry junk so a stale value cannot pass for a good one
        {code, feat, cnt, num, cyl_lo, cyl_hi} <= ~f[49:2];
        n_busy = 0;
        n_int = 0;
        repeat (8) begin
            #1;
            // An unknown level counts as high, so it cannot hide in the count
            n_busy += (busy === 1'b0) ? 0 : 1;
            n_int += (intrq === 1'b0) ? 0 : 1;
            @(posedge clk);
        end
    endtask
    // A media command ending in error is sent once more
    task automatic cmd(input logic [49:0] f);
        xfer(f);
        if ((f[1] ^ f[0]) && stat[ST_ERR] === 1'b1) xfer(f);
    endtask
endmodule // apc_host
`default_nettype wire

// file: dv/ata_power_pin_mode_commands_test.sv
// Self-checking bench for the idle, sleep and pin-function command block
`timescale 1ns/1ns
`default_nettype none
module ata_power_pin_mode_commands_test
    import apc_pkg::*;
;
    localparam int TK = 10;
    logic core_clk, nrst, host_reset, valid, busy, intrq, sleeping, auto_pd, pin_pd;
    logic [7:0] err_raw, stat_raw, code, feat, cnt, num, cl, ch, err_out, stat_out;
    logic [1:0] cls;
    logic [49:0] f;
    logic [31:0] tbl [5];
    int mismatches;
    int checks;
    // ==========================================================
    // Device and host
    apc_cmd #(.TICK_CYCLES(TK)) u_dut (.CORE_CLK(core_clk), .NRST(nrst), .CMD_VALID(valid),
        .CMD_CODE(code), .FEATURE(feat), .SEC_CNT(cnt), .SEC_NUM(num), .CYL_LOW(cl),
        .CYL_HIGH(ch), .CMD_CLASS(cls), .ERR_RAW(err_raw), .STAT_RAW(stat_raw),
        .HOST_RESET(host_reset), .BUSY(busy), .INTRQ(intrq), .SLEEPING(sleeping),
        .AUTO_PD_EN(auto_pd), .PIN_IS_PD(pin_pd), .ERR_OUT(err_out), .STAT_OUT(stat_out));
    apc_host u_host (.clk(core_clk), .busy(busy), .intrq(intrq), .stat(stat_out),
        .valid(valid), .code(code), .feat(feat), .cnt(cnt), .num(num), .cyl_lo(cl),
        .cyl_hi(ch), .cls(cls));
    // 10 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Pin-function command word with the full signature
    function automatic logic [49:0] pin(input logic [7:0] fv);
        return {OP_PINFN, fv, SIG_SEC_CNT, SIG_SEC_NUM, SIG_CYL_LOW, SIG_CYL_HIGH, CL_CTRL};
    endfunction
    // Issue a command, then check one busy pair and one interrupt
    task automatic run(input logic [49:0] w);
        u_host.cmd(w);
        #1;
        chk("busy_cycles", 8'h02, 8'(u_host.n_busy));
        chk("intrq_cycles", 8'h01, 8'(u_host.n_int));
    endtask
    // Sleep must stay off for a cycles, then be on within b more
    task automatic nap(input int a, input int b);
        repeat (a) @(posedge core_clk);
        #1;
        chk("awake", 8'h00, {7'h0, sleeping});
        repeat (b) @(posedge core_clk);
        #1;
        chk("asleep", 8'h01, {7'h0, sleeping});
    endtask
    task automatic rst();
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        #1;
    endtask
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #2000000;
        mismatches++;
        results();
    end
    // ==========================================================
    // Tests
    initial begin
        nrst = 1'b0;
        host_reset = 1'b0;
        err_raw = 8'h00;
        stat_raw = 8'h00;
        mismatches = 0;
        checks = 0;
        tbl = '{32'h20_01_d5_75, 32'h30_02_95_71, 32'h70_00_14_71, 32'h90_03_00_51,
            32'hec_00_04_71};
        rst();
        chk("auto_pd", 8'h01, {7'h0, auto_pd});
        chk("pin_pd", 8'h00, {7'h0, pin_pd});
        // Default timer is three ticks, counted from the first edge out of reset
        nap(3 * TK - 2, 1);
        $display("test reset_timer done");
        run({OP_IDLE_A, 40'h0, CL_CTRL});
        chk("woken", 8'h00, {7'h0, sleeping});
        // Timer restarts as the command completes, two edges after acceptance
        nap(3 * TK - 7, 1);
        run({OP_IDLE_B, 8'h00, 8'h05, 24'h0, CL_CTRL});
        nap(5 * TK - 7, 1);
        $display("test idle done");
        foreach (tbl[i]) begin
            if (i < 2) begin
                run({(i == 0) ? OP_SLEEP_A : OP_SLEEP_B, 40'h0, CL_CTRL});
                chk("sleep_cmd", 8'h01, {7'h0, sleeping});
            end
        end
        @(posedge core_clk);
        host_reset <= 1'b1;
        @(posedge core_clk);
        host_reset <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("reset_wake", 8'h00, {7'h0, sleeping});
        $display("test sleep done");
        run(pin(FEAT_PD));
        chk("pin_pd", 8'h01, {7'h0, pin_pd});
        for (int i = 0; i < 5; i++) begin
            run(pin(FEAT_WP) ^ (50'h1 << (2 + 8 * i)));
            chk("bad_err", 8'h04, err_out);
            chk("bad_stat", 8'h51, stat_out);
            chk("bad_pin", 8'h01, {7'h0, pin_pd});
        end
        rst();
        chk("kept_pin", 8'h01, {7'h0, pin_pd});
        run(pin(FEAT_WP));
        chk("pin_wp", 8'h00, {7'h0, pin_pd});
        $display("test pin_function done");
        // Every bit raised by the media engine; only the allowed ones may post
        @(posedge core_clk);
        err_raw <= 8'hff;
        stat_raw <= 8'hff;
        foreach (tbl[i]) begin
            f = {tbl[i][31:24], 40'h0, tbl[i][17:16]};
            run(f);
            chk("err_post", tbl[i][15:8], err_out);
            chk("stat_post", tbl[i][7:0], stat_out);
        end
        $display("test error_posting done");
        results();
    end
endmodule // ata_power_pin_mode_commands_test
`default_nettype wire
